// >>> hw/abu_regs.svh
`ifndef ABU_REGS_SVH
`define ABU_REGS_SVH

// register offsets on the plain register port
`define ABU_OFS_STATUS_CONTROL 3'h0
`define ABU_OFS_ADDRESS_HIGH   3'h1
`define ABU_OFS_ADDRESS_LOW    3'h2
`define ABU_OFS_WAIT_STATUS    3'h3
`define ABU_OFS_FLAG_CONTROL   3'h4

// field positions
`define ABU_BIT_BREAK_ENABLE   7
`define ABU_BIT_BREAK_ACTIVE   6
`define ABU_BIT_WAIT_EXIT      1
`define ABU_BIT_CLEAR_ENABLE   7

// reset values
`define ABU_RST_BYTE           8'h00
`define ABU_RST_ADDRESS        16'h0000

// break vectors, normal and monitor mode
`define ABU_VEC_NORMAL         16'hfffc
`define ABU_VEC_MONITOR        16'hfefc

`endif

// >>> hw/abu_pkg.sv
package abu_pkg;

    // break sequencing states, one-hot
    typedef enum logic [2:0] {
        ABU_IDLE  = 3'b001,
        ABU_PEND  = 3'b010,
        ABU_BREAK = 3'b100
    } abu_state_t;

    // register port request
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } abu_reg_req_t;

    // cpu bus observation
    typedef struct packed {
        logic [15:0] addr;
        logic        addr_valid;
        logic        opcode_fetch;
        logic        instr_boundary;
        logic        rti_exec;
        logic        low_power;
        logic        wait_mode;
    } abu_cpu_t;

    // all state of the breakpoint unit
    typedef struct packed {
        abu_state_t  st;
        logic        brk_enable;
        logic        brk_active;
        logic [15:0] brk_addr;
        logic        wait_exit_flag;
        logic        clear_enable;
        logic        armed;
        logic        pend_opcode;
        logic [15:0] vector;
        logic [7:0]  rdata;
        logic        vtst_s1;
        logic        vtst_s2;
    } abu_state_all_t;

endpackage : abu_pkg

// >>> hw/abu_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "abu_regs.svh"

// How it works
// - address match raises breakpoint request
// - force software interrupt, vector by mode
// - software break taken before next instruction
// - opcode match breaks before instruction executes
// - operand match breaks after instruction completes
// - return from interrupt ends break state
// - unchanged address gives no repeated break
// - new address write or reset rearms breaks
// - status clears in break allowed only with enable
// - break state halts timer counter
// - break with test voltage disables watchdog
// - enable bit seven gates address match
// - active bit set by match, cleared
// - two address bytes, cleared by reset
// - flag shows wait exit by break in emulation mode
// - no address match break in wait or stop
module abu_top (
    input  wire logic                  clk,
    input  wire logic                  rstn,
    input  wire abu_pkg::abu_reg_req_t reg_req,
    output var  logic [7:0]            reg_rdata,
    input  wire abu_pkg::abu_cpu_t     cpu,
    input  wire logic                  monitor_mode,
    input  wire logic                  emulation_mode,
    input  wire logic                  test_high_voltage,
    output var  logic                  breakpoint_request,
    output var  logic                  software_interrupt_force,
    output var  logic [15:0]           break_vector,
    output var  logic                  break_state,
    output var  logic                  status_clear_allow,
    output var  logic                  timer_halt,
    output var  logic                  watchdog_disable
);
    import abu_pkg::*;

    abu_state_all_t s;
    abu_state_all_t next_s;

    logic wr_sc;
    logic wr_hi;
    logic wr_lo;
    logic wr_ws;
    logic wr_fc;
    logic match;
    logic take;
    logic sw_break;

    // register write decode
    assign wr_sc = reg_req.wr && (reg_req.addr == `ABU_OFS_STATUS_CONTROL);
    assign wr_hi = reg_req.wr && (reg_req.addr == `ABU_OFS_ADDRESS_HIGH);
    assign wr_lo = reg_req.wr && (reg_req.addr == `ABU_OFS_ADDRESS_LOW);
    assign wr_ws = reg_req.wr && (reg_req.addr == `ABU_OFS_WAIT_STATUS);
    assign wr_fc = reg_req.wr && (reg_req.addr == `ABU_OFS_FLAG_CONTROL);

    // software request for a break
    // software break request
    assign sw_break = wr_sc && reg_req.wdata[`ABU_BIT_BREAK_ACTIVE];

    // address comparator, only in idle state and outside low power
    // address compare
    assign match = s.brk_enable && s.armed && cpu.addr_valid && !cpu.low_power
                   && (cpu.addr == s.brk_addr) && (s.st == ABU_IDLE);

    // break is taken at once for opcode hits, at boundary otherwise
    // opcode hit immediate
    assign take = (s.st == ABU_PEND) && (s.pend_opcode || cpu.instr_boundary);

    // next state
    always_comb begin
        next_s = s;
        next_s.vtst_s1 = test_high_voltage;
        next_s.vtst_s2 = s.vtst_s1;

        // read data stand one cycle after the read strobe
        next_s.rdata = 8'h00;
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                `ABU_OFS_STATUS_CONTROL: begin
                    next_s.rdata[`ABU_BIT_BREAK_ENABLE] = s.brk_enable;
                    next_s.rdata[`ABU_BIT_BREAK_ACTIVE] = s.brk_active;
                end
                `ABU_OFS_ADDRESS_HIGH: begin
                    next_s.rdata = s.brk_addr[15:8];
                end
                `ABU_OFS_ADDRESS_LOW: begin
                    next_s.rdata = s.brk_addr[7:0];
                end
                `ABU_OFS_WAIT_STATUS: begin
                    next_s.rdata[`ABU_BIT_WAIT_EXIT] = s.wait_exit_flag;
                end
                `ABU_OFS_FLAG_CONTROL: begin
                    next_s.rdata[`ABU_BIT_CLEAR_ENABLE] = s.clear_enable;
                end
                default: begin
                    next_s.rdata = 8'h00;
                end
            endcase
        end

        // control register writes
        // enable written
        if (wr_sc) begin
            next_s.brk_enable = reg_req.wdata[`ABU_BIT_BREAK_ENABLE];
            next_s.brk_active = reg_req.wdata[`ABU_BIT_BREAK_ACTIVE];
        end
        if (wr_fc) begin
            next_s.clear_enable = reg_req.wdata[`ABU_BIT_CLEAR_ENABLE];
        end
        if (wr_ws && !reg_req.wdata[`ABU_BIT_WAIT_EXIT]) begin
            next_s.wait_exit_flag = 1'b0;
        end

        if (wr_hi) begin
            next_s.brk_addr[15:8] = reg_req.wdata;
            next_s.armed          = 1'b1;
        end
        if (wr_lo) begin
            next_s.brk_addr[7:0] = reg_req.wdata;
            next_s.armed         = 1'b1;
        end

        // break sequencer
        unique case (s.st)
            ABU_IDLE: begin
                if (match) begin
                    next_s.st          = ABU_PEND;
                    next_s.pend_opcode = cpu.opcode_fetch;
                    next_s.armed       = wr_hi || wr_lo; // address write wins
                end else if (sw_break) begin
                    next_s.st          = ABU_PEND;
                    next_s.pend_opcode = 1'b0;
                end
            end
            ABU_PEND: begin
                if (take) begin
                    next_s.st          = ABU_BREAK;
                    next_s.pend_opcode = 1'b0;
                    next_s.vector = monitor_mode ? `ABU_VEC_MONITOR : `ABU_VEC_NORMAL;
                    if (cpu.wait_mode && emulation_mode) begin
                        next_s.wait_exit_flag = 1'b1;
                    end
                end
            end
            ABU_BREAK: begin
                if (cpu.rti_exec) begin
                    next_s.st = ABU_IDLE;
                end
            end
            default: begin
                next_s.st = ABU_IDLE;
            end
        endcase

        // hardware set wins over a software clear
        // match sets active
        if (match) begin
            next_s.brk_active = 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s.st             <= ABU_IDLE;
            s.brk_enable     <= 1'b0;
            s.brk_active     <= 1'b0;
            s.brk_addr       <= `ABU_RST_ADDRESS;
            s.wait_exit_flag <= 1'b0;
            s.clear_enable   <= 1'b0;
            s.armed          <= 1'b1;
            s.pend_opcode    <= 1'b0;
            s.vector         <= `ABU_VEC_NORMAL;
            s.rdata          <= `ABU_RST_BYTE;
            s.vtst_s1        <= 1'b0;
            s.vtst_s2        <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // outputs toward cpu and system integration logic
    assign reg_rdata                = s.rdata;
    assign breakpoint_request       = (s.st == ABU_PEND);
    assign software_interrupt_force = take;
    assign break_vector             = s.vector;
    assign break_state              = (s.st == ABU_BREAK);
    assign status_clear_allow       = (s.st != ABU_BREAK) || s.clear_enable;
    assign timer_halt               = (s.st == ABU_BREAK);
    assign watchdog_disable         = (s.st == ABU_BREAK) && s.vtst_s2;

    // checks on the sequencing
    a_match_request: assert property (
        @(posedge clk) disable iff (!rstn)
        match |=> breakpoint_request
    ) else $error("address match did not raise a request");

    a_vector_mode: assert property (
        @(posedge clk) disable iff (!rstn)
        take |=> (break_vector == ($past(monitor_mode) ? 16'hfefc : 16'hfffc))
    ) else $error("break vector does not follow mode");

    a_soft_break: assert property (
        @(posedge clk) disable iff (!rstn)
        (sw_break && s.st == ABU_IDLE && !match) |=> breakpoint_request && !s.pend_opcode
    ) else $error("software break not pending");

    a_opcode_now: assert property (
        @(posedge clk) disable iff (!rstn)
        (match && cpu.opcode_fetch) |=> software_interrupt_force ##1 break_state
    ) else $error("opcode break not taken next cycle");

    a_operand_wait: assert property (
        @(posedge clk) disable iff (!rstn)
        (breakpoint_request && !s.pend_opcode && !cpu.instr_boundary)
        |-> !software_interrupt_force
    ) else $error("operand break taken before boundary");

    a_rti_exit: assert property (
        @(posedge clk) disable iff (!rstn)
        (break_state && cpu.rti_exec) |=> !break_state
    ) else $error("return did not end break");

    a_no_repeat: assert property (
        @(posedge clk) disable iff (!rstn)
        (!s.armed && !wr_hi && !wr_lo) |=> !match
    ) else $error("repeated break without new address");

    a_rearm_write: assert property (
        @(posedge clk) disable iff (!rstn)
        (wr_hi || wr_lo) |=> s.armed
    ) else $error("address write did not rearm");

    a_flag_guard: assert property (
        @(posedge clk) disable iff (!rstn)
        (break_state && !s.clear_enable) |-> !status_clear_allow
    ) else $error("status clear allowed in break");

    a_timer_stop: assert property (
        @(posedge clk) disable iff (!rstn)
        $rose(break_state) |-> timer_halt
    ) else $error("timer running in break");

    a_watchdog_off: assert property (
        @(posedge clk) disable iff (!rstn)
        (break_state && s.vtst_s2) |-> watchdog_disable
    ) else $error("watchdog active under test voltage");

    a_enable_gate: assert property (
        @(posedge clk) disable iff (!rstn)
        !s.brk_enable |-> !match
    ) else $error("match while disabled");

    a_active_set: assert property (
        @(posedge clk) disable iff (!rstn)
        match |=> s.brk_active
    ) else $error("active bit not set on match");

    a_addr_store: assert property (
        @(posedge clk) disable iff (!rstn)
        wr_lo |=> (s.brk_addr[7:0] == $past(reg_req.wdata))
    ) else $error("low address byte not stored");

    a_wait_flag: assert property (
        @(posedge clk) disable iff (!rstn)
        (take && cpu.wait_mode && emulation_mode) |=> s.wait_exit_flag
    ) else $error("wait exit flag not set");

    a_low_power: assert property (
        @(posedge clk) disable iff (!rstn)
        cpu.low_power |-> !match
    ) else $error("match in low power mode");

    a_read_timing: assert property (
        @(posedge clk) disable iff (!rstn)
        (reg_req.rd && reg_req.addr == 3'h0)
        |=> (reg_rdata[7] == $past(s.brk_enable))
    ) else $error("control read data wrong");

    a_pend_hold: assert property (
        @(posedge clk) disable iff (!rstn)
        (breakpoint_request && !software_interrupt_force) |=> breakpoint_request
    ) else $error("pending break dropped before taken");

    a_take_enters: assert property (
        @(posedge clk) disable iff (!rstn)
        software_interrupt_force |=> (break_state && !breakpoint_request)
    ) else $error("forced interrupt did not enter break");

    a_break_hold: assert property (
        @(posedge clk) disable iff (!rstn)
        (break_state && !cpu.rti_exec) |=> break_state
    ) else $error("break ended without return");

    a_idle_quiet: assert property (
        @(posedge clk) disable iff (!rstn)
        !breakpoint_request |-> !software_interrupt_force
    ) else $error("interrupt forced with nothing pending");

    a_state_onehot: assert property (
        @(posedge clk) disable iff (!rstn)
        $onehot(s.st)
    ) else $error("sequencer state not one-hot");

    a_active_clear: assert property (
        @(posedge clk) disable iff (!rstn)
        (wr_sc && !reg_req.wdata[`ABU_BIT_BREAK_ACTIVE] && !match) |=> !s.brk_active
    ) else $error("active bit not cleared by write");

    a_enable_write: assert property (
        @(posedge clk) disable iff (!rstn)
        wr_sc |=> (s.brk_enable == $past(reg_req.wdata[`ABU_BIT_BREAK_ENABLE]))
    ) else $error("enable bit not written");

    a_high_store: assert property (
        @(posedge clk) disable iff (!rstn)
        wr_hi |=> (s.brk_addr[15:8] == $past(reg_req.wdata))
    ) else $error("high address byte not stored");

    a_high_read: assert property (
        @(posedge clk) disable iff (!rstn)
        (reg_req.rd && reg_req.addr == `ABU_OFS_ADDRESS_HIGH)
        |=> (reg_rdata == $past(s.brk_addr[15:8]))
    ) else $error("high address byte read wrong");

    a_timer_run: assert property (
        @(posedge clk) disable iff (!rstn)
        !break_state |-> !timer_halt
    ) else $error("timer halted outside break");

    a_watchdog_on: assert property (
        @(posedge clk) disable iff (!rstn)
        !break_state |-> !watchdog_disable
    ) else $error("watchdog off outside break");

    a_clear_free: assert property (
        @(posedge clk) disable iff (!rstn)
        !break_state |-> status_clear_allow
    ) else $error("status clear blocked outside break");

    a_repeat_block: assert property (
        @(posedge clk) disable iff (!rstn)
        match |=> (s.armed == ($past(wr_hi) || $past(wr_lo)))
    ) else $error("match left comparator armed");

    a_vector_hold: assert property (
        @(posedge clk) disable iff (!rstn)
        !take |=> $stable(break_vector)
    ) else $error("vector changed without a break");

    a_soft_active: assert property (
        @(posedge clk) disable iff (!rstn)
        sw_break |=> s.brk_active
    ) else $error("software break did not set active");

    a_wait_clear: assert property (
        @(posedge clk) disable iff (!rstn)
        (wr_ws && !reg_req.wdata[`ABU_BIT_WAIT_EXIT] && !take) |=> !s.wait_exit_flag
    ) else $error("wait exit flag not cleared");

    a_boundary_take: assert property (
        @(posedge clk) disable iff (!rstn)
        (breakpoint_request && cpu.instr_boundary) |-> software_interrupt_force
    ) else $error("pending break missed a boundary");

endmodule : abu_top
`default_nettype wire

// >>> dv/abu_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
// cpu and integration stand-in: two-byte instructions, fixed-length break routine
module abu_cpu_model (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              run,
    input  wire logic              sleep,
    input  wire logic [15:0]       start_pc,
    input  wire logic              software_interrupt_force,
    output var  abu_pkg::abu_cpu_t cpu
);
    import abu_pkg::*;
    logic [15:0] pc;
    logic        ph;
    logic [3:0]  svc;
    logic [15:0] last;
    // fetch sequencer; a forced interrupt enters the routine, then refetches the same pc
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pc   <= 16'h0000;
            ph   <= 1'b0;
            svc  <= 4'h0;
            last <= 16'h0000;
        end else begin
            last <= cpu.addr;
            if (software_interrupt_force) begin
                svc <= 4'hf;
                ph  <= 1'b0;
            end else if (svc != 4'h0) begin
                svc <= svc - 4'h1;
            end else if (!run) begin
                pc <= start_pc;
                ph <= 1'b0;
            end else if (!sleep) begin
                ph <= ~ph;
                pc <= ph ? pc + 16'h0002 : pc;
            end
        end
    end
    // bus outputs; a released bus shows the inverse of its last value
    always_comb begin
        cpu                = '0;
        cpu.addr_valid     = run && (svc == 4'h0);
        cpu.addr           = cpu.addr_valid ? pc + {15'h0000, ph} : ~last;
        cpu.opcode_fetch   = cpu.addr_valid && !ph;
        // a sleeping cpu sits between two instructions
        cpu.instr_boundary = cpu.addr_valid && (ph || sleep);
        cpu.rti_exec       = (svc == 4'h1);
        cpu.low_power      = sleep;
        cpu.wait_mode      = sleep;
    end
endmodule : abu_cpu_model
`default_nettype wire

// >>> dv/abu_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module abu_top_tb;
    import abu_pkg::*;
    logic              clk = 1'b0;
    logic              rstn = 1'b0;
    abu_reg_req_t      reg_req = '0;
    logic [7:0]        reg_rdata;
    abu_cpu_t          cpu;
    logic              monitor_mode = 1'b0;
    logic              emulation_mode = 1'b0;
    logic              test_high_voltage = 1'b0;
    logic              breakpoint_request;
    logic              software_interrupt_force;
    logic [15:0]       break_vector;
    logic              break_state;
    logic              status_clear_allow;
    logic              timer_halt;
    logic              watchdog_disable;
    logic              run = 1'b0;
    logic              sleep = 1'b0;
    logic [15:0]       start_pc = 16'h1230;
    logic [7:0]        d;
    int                n_fail = 0;
    int                comparisons = 0;

    // 125 MHz clock
    always #4 clk = ~clk;

    abu_top dut_u (.clk(clk), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .cpu(cpu), .monitor_mode(monitor_mode), .emulation_mode(emulation_mode),
        .test_high_voltage(test_high_voltage), .breakpoint_request(breakpoint_request),
        .software_interrupt_force(software_interrupt_force), .break_vector(break_vector),
        .break_state(break_state), .status_clear_allow(status_clear_allow),
        .timer_halt(timer_halt), .watchdog_disable(watchdog_disable));

    abu_cpu_model cpu_u (.clk(clk), .rstn(rstn), .run(run), .sleep(sleep),
        .start_pc(start_pc), .software_interrupt_force(software_interrupt_force), .cpu(cpu));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        reg_req <= '0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        reg_req <= '0;
        #1;
        v = reg_rdata;
    endtask : rd

    // brk selects break_state, else the forced interrupt pulse
    task automatic wait_for(input logic brk, input logic lvl);
        logic v;
        v = brk ? break_state : software_interrupt_force;
        for (int i = 0; i < 60 && v !== lvl; i++) begin
            @(posedge clk);
            #1;
            v = brk ? break_state : software_interrupt_force;
        end
        chk(v, lvl);
    endtask : wait_for

    task automatic no_break(input int n);
        int hits;
        hits = 0;
        repeat (n) begin
            @(posedge clk);
            #1;
            if (breakpoint_request !== 1'b0) hits++;
        end
        chk(hits[15:0], 16'h0000);
    endtask : no_break

    task automatic reset_values;
        chk(break_vector, 16'hfffc);
        chk(status_clear_allow, 1'b1);
        for (int i = 0; i < 6; i++) begin
            rd(i[2:0], d);
            chk(d, 8'h00);
        end
    endtask : reset_values

    task automatic opcode_break;
        wr(3'h1, 8'h12);
        wr(3'h2, 8'h34);
        rd(3'h1, d);
        chk(d, 8'h12);
        rd(3'h2, d);
        chk(d, 8'h34);
        wr(3'h0, 8'h80);
        run <= 1'b1;
        wait_for(1'b0, 1'b1);
        chk(breakpoint_request, 1'b1);
        chk(cpu.addr, 16'h1235);
        @(posedge clk);
        #1;
        chk({break_state, timer_halt}, 2'b11);
        chk(break_vector, 16'hfffc);
        chk(status_clear_allow, 1'b0);
        chk(watchdog_disable, 1'b0);
        rd(3'h0, d);
        chk(d, 8'hc0);
        // routine clears active but keeps the address
        wr(3'h0, 8'h80);
        rd(3'h0, d);
        chk(d, 8'h80);
        wait_for(1'b1, 1'b0);
        chk(timer_halt, 1'b0);
        no_break(12);
        run <= 1'b0;
    endtask : opcode_break

    // new address on an operand, taken at the boundary
    task automatic monitor_rearm;
        wr(3'h2, 8'h35);
        monitor_mode <= 1'b1;
        run <= 1'b1;
        wait_for(1'b0, 1'b1);
        chk(cpu.addr, 16'h1237);
        @(posedge clk);
        #1;
        chk(break_vector, 16'hfefc);
        wait_for(1'b1, 1'b0);
        run <= 1'b0;
    endtask : monitor_rearm

    task automatic software_break;
        start_pc <= 16'h2000;
        wr(3'h4, 8'h80);
        monitor_mode <= 1'b0;
        test_high_voltage <= 1'b1;
        run <= 1'b1;
        wr(3'h0, 8'h40);
        wait_for(1'b0, 1'b1);
        chk(cpu.instr_boundary, 1'b1);
        @(posedge clk);
        #1;
        chk(status_clear_allow, 1'b1);
        chk(watchdog_disable, 1'b1);
        chk(break_vector, 16'hfffc);
        wait_for(1'b1, 1'b0);
        run <= 1'b0;
        test_high_voltage <= 1'b0;
        wr(3'h4, 8'h00);
    endtask : software_break

    task automatic quiet_cases;
        start_pc <= 16'h1230;
        wr(3'h0, 8'h00);
        wr(3'h2, 8'h34);
        run <= 1'b1;
        no_break(16);
        run <= 1'b0;
        start_pc <= 16'h1234;
        sleep <= 1'b1;
        wr(3'h0, 8'h80);
        emulation_mode <= 1'b1;
        run <= 1'b1;
        no_break(16);
        // software break wakes the sleeping cpu
        wr(3'h0, 8'h40);
        #1;
        chk(software_interrupt_force, 1'b1);
        wait_for(1'b1, 1'b0);
        rd(3'h3, d);
        chk(d, 8'h02);
        wr(3'h3, 8'h00);
        rd(3'h3, d);
        chk(d, 8'h00);
        run <= 1'b0;
        sleep <= 1'b0;
    endtask : quiet_cases

    task automatic complete_run;
        if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        reset_values;
        opcode_break;
        monitor_rearm;
        software_break;
        quiet_cases;
        complete_run;
    end

    // watchdog against a hang
    initial begin
        #40000;
        n_fail++;
        complete_run;
    end
endmodule : abu_top_tb
`default_nettype wire
